// file: shared/rsc_pkg.sv
package rsc_pkg;
	localparam logic [15:0] MODE0_OFFSET = 16'h0004;
	localparam logic [15:0] CAUSE_OFFSET = 16'h000b;
	localparam logic [15:0] WDOG_OPT_OFFSET = 16'hffdb;
	localparam logic [15:0] START_OPT_OFFSET = 16'hffff;
	localparam logic [15:0] ID_FIRST_ADDR = 16'hffdf;
	localparam logic [15:0] ID_LAST_ADDR = 16'hfffb;
	localparam int ID_COUNT = 7;
	localparam logic [3:0] ID_GAP_SLOT = 4'h2;
	localparam int SOFT_RESET_BIT = 3;
	localparam int WARM_BIT = 0;
	localparam int WDOG_STOP_BIT = 0;
	localparam int CP_DEFER_BIT = 2;
	localparam int CP_OFF_BIT = 3;
	localparam int THR_LO_BIT = 4;
	localparam int THR_HI_BIT = 5;
	localparam int MON_OFF_BIT = 6;
	localparam int CSP_OFF_BIT = 7;
	localparam int PERIOD_LO_BIT = 0;
	localparam int PERIOD_HI_BIT = 1;
	localparam int WINDOW_LO_BIT = 2;
	localparam int WINDOW_HI_BIT = 3;
	localparam logic [7:0] MODE0_RESET = 8'h00;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [2:0] CAUSE_RESET = 3'h0;
	localparam logic [2:0] CAUSE_PIN = 3'h1;
	localparam logic [2:0] CAUSE_SOFT = 3'h2;
	localparam logic [2:0] CAUSE_WDOG = 3'h4;
	localparam int LOCO_TICKS = 32;
	localparam logic [3:0] FETCH_LAST = 4'h8;
	localparam logic [11:0] THR_MV_0 = 12'hed8;
	localparam logic [11:0] THR_MV_1 = 12'hb22;
	localparam logic [11:0] THR_MV_2 = 12'h92e;
	localparam logic [11:0] THR_MV_3 = 12'h76c;
	localparam logic [13:0] PERIOD_0 = 14'h03ff;
	localparam logic [13:0] PERIOD_1 = 14'h0fff;
	localparam logic [13:0] PERIOD_2 = 14'h1fff;
	localparam logic [13:0] PERIOD_3 = 14'h3fff;
	localparam logic [6:0] WINDOW_0 = 7'h19;
	localparam logic [6:0] WINDOW_1 = 7'h32;
	localparam logic [6:0] WINDOW_2 = 7'h4b;
	localparam logic [6:0] WINDOW_3 = 7'h64;

	typedef enum logic [1:0] {
		ST_POWER = 2'b00,
		ST_HOLD = 2'b01,
		ST_FETCH = 2'b10,
		ST_RUN = 2'b11
	} rsc_state_t;

	// flash address of each byte pulled in during the reset sequence
	// id bytes sit every fourth address, with one slot of that run left out
	function automatic logic [15:0] fetch_addr(input logic [3:0] idx);
		logic [3:0] slot;
		slot = idx - 4'h2;
		if (slot >= ID_GAP_SLOT) begin
			slot = slot + 4'h1;
		end
		case (idx)
			4'h0: fetch_addr = START_OPT_OFFSET;
			4'h1: fetch_addr = WDOG_OPT_OFFSET;
			default: fetch_addr = ID_FIRST_ADDR + {10'h000, slot, 2'b00};
		endcase
	endfunction : fetch_addr

	function automatic logic is_id_addr(input logic [15:0] a);
		logic [15:0] ofs;
		ofs = a - ID_FIRST_ADDR;
		is_id_addr = (a >= ID_FIRST_ADDR) && (a <= ID_LAST_ADDR) && (ofs[1:0] == 2'b00) && (ofs[5:2] != ID_GAP_SLOT);
	endfunction : is_id_addr

	// memory slot of an id byte address, closing up the skipped position
	function automatic logic [2:0] id_slot(input logic [15:0] a);
		logic [15:0] ofs;
		ofs = a - ID_FIRST_ADDR;
		if (ofs[5:2] > ID_GAP_SLOT) begin
			id_slot = 3'(ofs[5:2] - 4'h1);
		end else begin
			id_slot = ofs[4:2];
		end
	endfunction : id_slot
endpackage : rsc_pkg

// file: src/rsc_id_mem.sv
module rsc_id_mem import rsc_pkg::*; #(
	parameter int DATA_W = 8,
	parameter int DEPTH = ID_COUNT,
	parameter int ADDR_W = 3,
	parameter logic [DATA_W-1:0] ERASE_VAL = ERASED_BYTE
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic rd_en,
	input wire logic rd_use_mem,
	input wire logic [ADDR_W-1:0] rd_addr,
	input wire logic [DATA_W-1:0] rd_bypass,
	output logic [DATA_W-1:0] rd_data
);
	localparam logic [ADDR_W-1:0] LAST = ADDR_W'(DEPTH - 1);
	logic [DATA_W-1:0] mem_reg [DEPTH];

	// contents start at the erased value until the reset sequence fills them
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= ERASE_VAL;
			end
		end else if (clk_en && wr_en && wr_addr <= LAST) begin
			mem_reg[wr_addr] <= wr_data;
		end
	end

	// one read register serves both the id bytes and the register file
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rd_data <= '0;
		end else if (clk_en && rd_en) begin
			if (rd_use_mem && rd_addr <= LAST) begin
				rd_data <= mem_reg[rd_addr];
			end else begin
				rd_data <= rd_bypass;
			end
		end
	end
endmodule : rsc_id_mem

// file: src/rsc_reset_ctrl.sv
module rsc_reset_ctrl import rsc_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [7:0] reg_rdata,
	input wire logic reset_pin_n,
	input wire logic supply_ok,
	input wire logic loco_clk,
	input wire logic wdog_underflow,
	input wire logic mode_write_unlock,
	input wire logic wdog_reset_select,
	input wire logic monitor0_reset_enable,
	output logic [15:0] flash_addr,
	output logic flash_rd,
	input wire logic [7:0] flash_rdata,
	output logic chip_reset_n,
	output logic port_hiz,
	output logic reset_release,
	output logic wdog_autostart,
	output logic code_protect_on,
	output logic [1:0] supply_threshold,
	output logic [11:0] supply_threshold_mv,
	output logic monitor_reset_on,
	output logic count_src_protect_on,
	output logic [13:0] wdog_period,
	output logic [6:0] wdog_window_pct
);
	localparam logic [4:0] LOCO_LAST = 5'(LOCO_TICKS - 1);

	rsc_state_t state_reg;
	rsc_state_t state_next;
	logic [2:0] in_s1_reg;
	logic [2:0] in_s2_reg;
	logic [2:0] in_s3_reg;
	logic [2:0] in_filt_reg;
	logic loco_prev_reg;
	logic [4:0] tick_cnt_reg;
	logic [3:0] idx_reg;
	logic [1:0] phase_reg;
	logic [7:0] ofs_reg;
	logic [7:0] watchdog_option_byte_reg;
	logic [2:0] cause_reg;
	logic warm_reg;
	logic chip_reset_n_reg;
	logic port_hiz_reg;
	logic reset_release_reg;
	logic flash_rd_reg;
	logic [15:0] flash_addr_reg;
	logic wdog_autostart_reg;
	logic code_protect_on_reg;
	logic [1:0] supply_threshold_reg;
	logic [11:0] supply_threshold_mv_reg;
	logic monitor_reset_on_reg;
	logic count_src_protect_on_reg;
	logic [13:0] wdog_period_reg;
	logic [6:0] wdog_window_pct_reg;
	logic pin_f;
	logic sup_f;
	logic loco_tick;
	logic running;
	logic mode_wr;
	logic cause_wr;
	logic src_pin;
	logic src_volt;
	logic src_wdog;
	logic src_soft;
	logic capture;
	logic fetch_done;
	logic [7:0] rd_bypass;

	// pins pass three flops; a level counts once stages two and three agree
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			in_s1_reg <= 3'h0;
			in_s2_reg <= 3'h0;
			in_s3_reg <= 3'h0;
			in_filt_reg <= 3'h0;
			loco_prev_reg <= 1'b0;
		end else if (clk_en) begin
			in_s1_reg <= {loco_clk, supply_ok, reset_pin_n};
			in_s2_reg <= in_s1_reg;
			in_s3_reg <= in_s2_reg;
			in_filt_reg <= (in_s2_reg & in_s3_reg) | (in_filt_reg & (in_s2_reg | in_s3_reg));
			loco_prev_reg <= in_filt_reg[2];
		end
	end

	assign pin_f = in_filt_reg[0];
	assign sup_f = in_filt_reg[1];
	assign loco_tick = in_filt_reg[2] & ~loco_prev_reg;
	assign running = (state_reg == ST_RUN);
	assign mode_wr = reg_we && (reg_addr == MODE0_OFFSET);
	assign cause_wr = reg_we && (reg_addr == CAUSE_OFFSET);

	// reset sources
	assign src_pin = ~pin_f && (state_reg != ST_POWER);
	// one threshold, selected at reset, guards power-on and brown-out alike
	assign src_volt = running && monitor_reset_on_reg && monitor0_reset_enable && ~sup_f;
	assign src_wdog = running && wdog_underflow && wdog_reset_select;
	assign src_soft = running && mode_wr && mode_write_unlock && reg_wdata[SOFT_RESET_BIT];

	assign capture = (state_reg == ST_FETCH) && (phase_reg == 2'h2);
	assign fetch_done = capture && (idx_reg == FETCH_LAST);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_POWER: begin
				if (sup_f && loco_tick && tick_cnt_reg == LOCO_LAST) begin
					state_next = ST_FETCH;
				end
			end
			ST_HOLD: begin
				if (pin_f) begin
					state_next = ST_FETCH;
				end
			end
			ST_FETCH: begin
				if (fetch_done) begin
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				state_next = ST_RUN;
			end
			default: begin
				state_next = ST_POWER;
			end
		endcase
		if (src_pin) begin
			state_next = ST_HOLD;
		end else if (src_volt) begin
			state_next = ST_POWER;
		end else if (src_wdog || src_soft) begin
			state_next = ST_HOLD;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_reg <= ST_POWER;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	// low-speed ticks counted while the supply stays above threshold
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			tick_cnt_reg <= 5'h00;
		end else if (clk_en) begin
			if (state_reg != ST_POWER || !sup_f) begin
				tick_cnt_reg <= 5'h00;
			end else if (loco_tick) begin
				tick_cnt_reg <= tick_cnt_reg + 5'h01;
			end
		end
	end

	// option and id bytes read from flash: issue, wait, capture
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			idx_reg <= 4'h0;
			phase_reg <= 2'h0;
			flash_rd_reg <= 1'b0;
			flash_addr_reg <= 16'h0000;
		end else if (clk_en) begin
			if (state_reg != ST_FETCH || state_next != ST_FETCH) begin
				idx_reg <= 4'h0;
				phase_reg <= 2'h0;
				flash_rd_reg <= 1'b0;
			end else begin
				case (phase_reg)
					2'h0: begin
						flash_rd_reg <= 1'b1;
						flash_addr_reg <= fetch_addr(idx_reg);
						phase_reg <= 2'h1;
					end
					2'h1: begin
						flash_rd_reg <= 1'b0;
						phase_reg <= 2'h2;
					end
					default: begin
						idx_reg <= idx_reg + 4'h1;
						phase_reg <= 2'h0;
					end
				endcase
			end
		end
	end

	// shadows stay fixed from the sequence until the next reset
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ofs_reg <= ERASED_BYTE;
			watchdog_option_byte_reg <= ERASED_BYTE;
		end else if (clk_en && capture) begin
			if (idx_reg == 4'h0) begin
				ofs_reg <= flash_rdata;
			end else if (idx_reg == 4'h1) begin
				watchdog_option_byte_reg <= flash_rdata;
			end
		end
	end

	// decoded option settings, loaded when the fetch ends, on the same edge that captures the last id byte
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wdog_autostart_reg <= 1'b0;
			code_protect_on_reg <= 1'b0;
			supply_threshold_reg <= 2'h0;
			supply_threshold_mv_reg <= THR_MV_0;
			monitor_reset_on_reg <= 1'b0;
			count_src_protect_on_reg <= 1'b0;
			wdog_period_reg <= PERIOD_0;
			wdog_window_pct_reg <= WINDOW_0;
		end else if (clk_en && fetch_done) begin
			wdog_autostart_reg <= ~ofs_reg[WDOG_STOP_BIT];
			code_protect_on_reg <= ofs_reg[CP_DEFER_BIT] & ~ofs_reg[CP_OFF_BIT];
			supply_threshold_reg <= ofs_reg[THR_HI_BIT:THR_LO_BIT];
			case (ofs_reg[THR_HI_BIT:THR_LO_BIT])
				2'h0: supply_threshold_mv_reg <= THR_MV_0;
				2'h1: supply_threshold_mv_reg <= THR_MV_1;
				2'h2: supply_threshold_mv_reg <= THR_MV_2;
				default: supply_threshold_mv_reg <= THR_MV_3;
			endcase
			monitor_reset_on_reg <= ~ofs_reg[MON_OFF_BIT];
			count_src_protect_on_reg <= ~ofs_reg[CSP_OFF_BIT];
			case (watchdog_option_byte_reg[PERIOD_HI_BIT:PERIOD_LO_BIT])
				2'h0: wdog_period_reg <= PERIOD_0;
				2'h1: wdog_period_reg <= PERIOD_1;
				2'h2: wdog_period_reg <= PERIOD_2;
				default: wdog_period_reg <= PERIOD_3;
			endcase
			case (watchdog_option_byte_reg[WINDOW_HI_BIT:WINDOW_LO_BIT])
				2'h0: wdog_window_pct_reg <= WINDOW_0;
				2'h1: wdog_window_pct_reg <= WINDOW_1;
				2'h2: wdog_window_pct_reg <= WINDOW_2;
				default: wdog_window_pct_reg <= WINDOW_3;
			endcase
		end
	end

	// cause flags and the warm flag
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cause_reg <= CAUSE_RESET;
			warm_reg <= 1'b0;
		end else if (clk_en) begin
			if (state_next == ST_POWER && state_reg != ST_POWER) begin
				cause_reg <= CAUSE_RESET;
				warm_reg <= 1'b0;
			end else if (state_next == ST_HOLD && state_reg != ST_HOLD) begin
				if (src_pin) begin
					cause_reg <= CAUSE_PIN;
				end else if (src_wdog) begin
					cause_reg <= CAUSE_WDOG;
				end else begin
					cause_reg <= CAUSE_SOFT;
				end
			end else if (running && cause_wr && reg_wdata[WARM_BIT]) begin
				warm_reg <= 1'b1;
			end
		end
	end

	// pin, reset and release outputs
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			port_hiz_reg <= 1'b1;
			chip_reset_n_reg <= 1'b0;
			reset_release_reg <= 1'b0;
		end else if (clk_en) begin
			port_hiz_reg <= ~pin_f;
			// ram is not on this reset and keeps its contents
			chip_reset_n_reg <= (state_next == ST_RUN);
			reset_release_reg <= (state_reg == ST_FETCH) && (state_next == ST_RUN);
		end
	end

	// read mux; warm flag has no meaning with the monitor disabled, shown as 0 while monitor0_reset_enable is low
	always_comb begin
		rd_bypass = 8'h00;
		case (reg_addr)
			MODE0_OFFSET: rd_bypass = MODE0_RESET;
			CAUSE_OFFSET: rd_bypass = {4'h0, cause_reg, warm_reg & monitor0_reset_enable};
			START_OPT_OFFSET: rd_bypass = ofs_reg;
			WDOG_OPT_OFFSET: rd_bypass = watchdog_option_byte_reg;
			default: rd_bypass = 8'h00;
		endcase
	end

	rsc_id_mem #(
		.DATA_W(8),
		.DEPTH(ID_COUNT),
		.ADDR_W(3),
		.ERASE_VAL(ERASED_BYTE)
	) u_id_mem (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.wr_en(capture && idx_reg >= 4'h2),
		.wr_addr(3'(idx_reg - 4'h2)),
		.wr_data(flash_rdata),
		.rd_en(reg_re),
		.rd_use_mem(is_id_addr(reg_addr)),
		.rd_addr(id_slot(reg_addr)),
		.rd_bypass(rd_bypass),
		.rd_data(reg_rdata)
	);

	assign flash_addr = flash_addr_reg;
	assign flash_rd = flash_rd_reg;
	assign chip_reset_n = chip_reset_n_reg;
	assign port_hiz = port_hiz_reg;
	assign reset_release = reset_release_reg;
	assign wdog_autostart = wdog_autostart_reg;
	assign code_protect_on = code_protect_on_reg;
	assign supply_threshold = supply_threshold_reg;
	assign supply_threshold_mv = supply_threshold_mv_reg;
	assign monitor_reset_on = monitor_reset_on_reg;
	assign count_src_protect_on = count_src_protect_on_reg;
	assign wdog_period = wdog_period_reg;
	assign wdog_window_pct = wdog_window_pct_reg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_fetch_end;
		clk_en && state_reg == ST_FETCH && fetch_done;
	endsequence

	sequence s_released;
		reset_release_reg && chip_reset_n_reg && state_reg == ST_RUN;
	endsequence

	soft_reset_fire_a: assert property (clk_en && src_soft && !src_volt |=> !chip_reset_n_reg && state_reg == ST_HOLD)
		else $error("software reset did not assert chip reset");
	mode_read_zero_a: assert property (clk_en && reg_re && reg_addr == MODE0_OFFSET |=> reg_rdata == 8'h00)
		else $error("mode register read not zero");
	mode_write_lock_a: assert property (clk_en && running && mode_wr && !mode_write_unlock && pin_f
		&& !src_volt && !src_wdog |=> state_reg == ST_RUN)
		else $error("locked mode write took effect");
	port_hiz_pin_a: assert property (clk_en && !pin_f |=> port_hiz_reg)
		else $error("ports not released while pin low");
	cause_pin_flag_a: assert property (clk_en && running && !pin_f |=> cause_reg == CAUSE_PIN && !chip_reset_n_reg)
		else $error("pin reset not recorded");
	cold_clear_a: assert property (clk_en && state_reg == ST_POWER |=> !warm_reg)
		else $error("warm flag set during power reset");
	warm_keep_a: assert property (clk_en && running && state_next == ST_HOLD |=> warm_reg == $past(warm_reg))
		else $error("warm flag changed by warm reset");
	warm_set_a: assert property (clk_en && running && cause_wr && reg_wdata[WARM_BIT]
		&& state_next == ST_RUN |=> warm_reg)
		else $error("warm flag not set by write");
	por_count_a: assert property (state_reg == ST_POWER && state_next == ST_FETCH |-> tick_cnt_reg == LOCO_LAST)
		else $error("power release before 32 ticks");
	wdog_gate_a: assert property (clk_en && running && wdog_underflow && !wdog_reset_select && pin_f
		&& !src_volt && !src_soft |=> state_reg == ST_RUN)
		else $error("watchdog reset while not selected");
	release_pulse_a: assert property (s_fetch_end ##0 state_next == ST_RUN |=> s_released)
		else $error("release not signalled after fetch");
	threshold_cfg_a: assert property (s_fetch_end |=> supply_threshold_reg == ofs_reg[THR_HI_BIT:THR_LO_BIT])
		else $error("threshold not taken from option byte");
endmodule : rsc_reset_ctrl

// file: tb/rsc_flash_model.sv
module rsc_flash_model import rsc_pkg::*; (
	input wire logic clk_sys,
	input wire logic [15:0] flash_addr,
	input wire logic flash_rd,
	input wire logic [7:0] start_opt,
	input wire logic [7:0] wdog_opt,
	output logic [7:0] flash_rdata,
	output logic loco_clk
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		flash_rdata = 8'h00;
		loco_clk = 1'b0;
	end
	// low-speed oscillator runs free, phase unrelated to clk_sys
	always #41 loco_clk = ~loco_clk;
	// data stands one cycle after the read, then flips so a late capture shows up
	always @(posedge clk_sys) begin
		if (flash_rd) begin
			case (flash_addr)
				START_OPT_OFFSET: flash_rdata <= start_opt;
				WDOG_OPT_OFFSET: flash_rdata <= wdog_opt;
				default: flash_rdata <= flash_addr[7:0] ^ 8'h5a;
			endcase
		end else begin
			flash_rdata <= ~flash_rdata;
		end
	end
endmodule : rsc_flash_model

// file: tb/rsc_reset_ctrl_tb.sv
module rsc_reset_ctrl_tb import rsc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rst_n, clk_en, reg_we, reg_re, reset_pin_n, supply_ok, loco_clk, wdog_underflow;
	logic mode_write_unlock, wdog_reset_select, monitor0_reset_enable, flash_rd, chip_reset_n;
	logic port_hiz, reset_release, wdog_autostart, code_protect_on, monitor_reset_on, count_src_protect_on;
	logic [15:0] reg_addr, flash_addr;
	logic [7:0] reg_wdata, reg_rdata, flash_rdata, start_opt, wdog_opt, s, w;
	logic [1:0] supply_threshold, j;
	logic [11:0] supply_threshold_mv;
	logic [13:0] wdog_period;
	logic [6:0] wdog_window_pct;
	int n_errors = 0;
	int n_tests = 0;

	always #4 clk_sys = ~clk_sys;

	rsc_reset_ctrl dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
		.reset_pin_n(reset_pin_n), .supply_ok(supply_ok), .loco_clk(loco_clk), .wdog_underflow(wdog_underflow),
		.mode_write_unlock(mode_write_unlock), .wdog_reset_select(wdog_reset_select),
		.monitor0_reset_enable(monitor0_reset_enable), .flash_addr(flash_addr), .flash_rd(flash_rd),
		.flash_rdata(flash_rdata), .chip_reset_n(chip_reset_n), .port_hiz(port_hiz),
		.reset_release(reset_release), .wdog_autostart(wdog_autostart), .code_protect_on(code_protect_on),
		.supply_threshold(supply_threshold), .supply_threshold_mv(supply_threshold_mv),
		.monitor_reset_on(monitor_reset_on), .count_src_protect_on(count_src_protect_on),
		.wdog_period(wdog_period), .wdog_window_pct(wdog_window_pct));

	rsc_flash_model flash_u (.clk_sys(clk_sys), .flash_addr(flash_addr), .flash_rd(flash_rd),
		.start_opt(start_opt), .wdog_opt(wdog_opt), .flash_rdata(flash_rdata), .loco_clk(loco_clk));

	task automatic end_of_test;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_of_test

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clk_sys);
		reg_we <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string name);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clk_sys);
		reg_re <= 1'b0;
		#1 chk(name, 16'(exp), 16'(reg_rdata));
	endtask : rd

	task automatic wait_run;
		int n;
		n = 0;
		while (chip_reset_n !== 1'b1 && n < 3000) begin
			@(posedge clk_sys);
			#1 n++;
		end
		chk("run", 16'h1, 16'(chip_reset_n));
		chk("release", 16'h1, 16'(reset_release));
		@(posedge clk_sys);
		#1 chk("release_once", 16'h0, 16'(reset_release));
	endtask : wait_run

	task automatic pin_reset;
		@(posedge clk_sys);
		reset_pin_n <= 1'b0;
		repeat (8) @(posedge clk_sys);
		#1 chk("hiz_low", 16'h1, 16'(port_hiz));
		chk("pin_hold", 16'h0, 16'(chip_reset_n));
		@(posedge clk_sys);
		reset_pin_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
		#1 chk("hiz_high", 16'h0, 16'(port_hiz));
		wait_run();
	endtask : pin_reset

	task automatic cfg(input logic [7:0] so, input logic [7:0] wo);
		logic [11:0] mv [4] = '{12'd3800, 12'd2850, 12'd2350, 12'd1900};
		logic [13:0] per [4] = '{14'h03ff, 14'h0fff, 14'h1fff, 14'h3fff};
		logic [6:0] pct [4] = '{7'd25, 7'd50, 7'd75, 7'd100};
		chk("autostart", 16'(!so[0]), 16'(wdog_autostart));
		chk("protect", 16'(so[2] && !so[3]), 16'(code_protect_on));
		chk("thr", 16'(so[5:4]), 16'(supply_threshold));
		chk("thr_mv", 16'(mv[so[5:4]]), 16'(supply_threshold_mv));
		chk("monitor", 16'(!so[6]), 16'(monitor_reset_on));
		chk("csp", 16'(!so[7]), 16'(count_src_protect_on));
		chk("period", 16'(per[wo[1:0]]), 16'(wdog_period));
		chk("window", 16'(pct[wo[3:2]]), 16'(wdog_window_pct));
		rd(START_OPT_OFFSET, so, "start_opt");
		rd(WDOG_OPT_OFFSET, wo, "wdog_opt");
	endtask : cfg

	initial begin
		#200000;
		n_errors++;
		end_of_test();
	end

	initial begin
		{rst_n, reg_we, reg_re, wdog_underflow, mode_write_unlock, wdog_reset_select} = '0;
		{clk_en, reset_pin_n, supply_ok, monitor0_reset_enable} = 4'hf;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		start_opt = 8'hff;
		wdog_opt = 8'hff;
		repeat (11) @(posedge clk_sys);
		#1 chk("rst_hiz", 16'h1, 16'(port_hiz));
		chk("rst_chip", 16'h0, 16'(chip_reset_n));
		@(posedge clk_sys);
		rst_n <= 1'b1;
		wait_run();
		cfg(8'hff, 8'hff);
		for (int k = 0; k < 8; k++) if (k != 2) rd(ID_FIRST_ADDR + 16'(4 * k), (8'hdf + 8'(4 * k)) ^ 8'h5a, "id");
		rd(16'hffe7, 8'h00, "id_gap");
		rd(CAUSE_OFFSET, 8'h00, "cause_cold");
		rd(16'h0100, 8'h00, "unmapped");
		wr(CAUSE_OFFSET, 8'hfe);
		rd(CAUSE_OFFSET, 8'h00, "cause_ro");
		wr(CAUSE_OFFSET, 8'h01);
		rd(CAUSE_OFFSET, 8'h01, "warm_set");
		wr(CAUSE_OFFSET, 8'h00);
		rd(CAUSE_OFFSET, 8'h01, "warm_keep");
		monitor0_reset_enable <= 1'b0;
		rd(CAUSE_OFFSET, 8'h00, "warm_undef");
		monitor0_reset_enable <= 1'b1;
		for (int i = 3; i >= 0; i--) begin
			j = 2'(i);
			s = {j[0], j[1], j, ~j[0], j[1], 1'b1, j[0]};
			w = {4'hf, j[0], j[1], j};
			start_opt <= s;
			wdog_opt <= w;
			pin_reset();
			cfg(s, w);
			rd(CAUSE_OFFSET, 8'h03, "cause_pin");
		end
		start_opt <= 8'hff;
		wdog_opt <= 8'hff;
		wr(START_OPT_OFFSET, 8'h55);
		repeat (20) @(posedge clk_sys);
		cfg(s, w);
		start_opt <= s;
		wdog_opt <= w;
		wr(MODE0_OFFSET, 8'h08);
		repeat (4) @(posedge clk_sys);
		#1 chk("locked", 16'h1, 16'(chip_reset_n));
		mode_write_unlock <= 1'b1;
		wr(MODE0_OFFSET, 8'h08);
		#1 chk("soft_go", 16'h0, 16'(chip_reset_n));
		wait_run();
		mode_write_unlock <= 1'b0;
		rd(CAUSE_OFFSET, 8'h05, "cause_soft");
		rd(MODE0_OFFSET, 8'h00, "mode_rd");
		for (int i = 0; i < 2; i++) begin
			wdog_reset_select <= i[0];
			@(posedge clk_sys);
			wdog_underflow <= 1'b1;
			@(posedge clk_sys);
			wdog_underflow <= 1'b0;
			#1 chk("wdog", 16'(!i[0]), 16'(chip_reset_n));
		end
		wait_run();
		wdog_reset_select <= 1'b0;
		rd(CAUSE_OFFSET, 8'h09, "cause_wdog");
		monitor0_reset_enable <= 1'b0;
		supply_ok <= 1'b0;
		repeat (8) @(posedge clk_sys);
		#1 chk("bo_off", 16'h1, 16'(chip_reset_n));
		@(posedge clk_sys);
		monitor0_reset_enable <= 1'b1;
		repeat (8) @(posedge clk_sys);
		#1 chk("bo_on", 16'h0, 16'(chip_reset_n));
		@(posedge clk_sys);
		supply_ok <= 1'b1;
		// 28 oscillator periods is short of the 32 ticks needed
		repeat (287) @(posedge clk_sys);
		#1 chk("loco_wait", 16'h0, 16'(chip_reset_n));
		wait_run();
		rd(CAUSE_OFFSET, 8'h00, "cause_bo");
		cfg(s, w);
		end_of_test();
	end
endmodule : rsc_reset_ctrl_tb
